// [core/carrier_pwm_pkg.sv]
package carrier_pwm_pkg;

    // register indices on the plain port
    localparam logic [3:0] ADDR_CTRL      = 4'h0;
    localparam logic [3:0] ADDR_CLKSEL    = 4'h1;
    localparam logic [3:0] ADDR_CYCLE_CMP = 4'h2;
    localparam logic [3:0] ADDR_LOW_CMP   = 4'h3;
    localparam logic [3:0] ADDR_HIGH_CMP  = 4'h4;
    localparam logic [3:0] ADDR_OUT_CTRL  = 4'h5;
    localparam logic [3:0] ADDR_PORT      = 4'h6;
    localparam logic [3:0] ADDR_CYCLE_CNT = 4'h7;
    localparam logic [3:0] ADDR_CARR_CNT  = 4'h8;
    localparam logic [3:0] ADDR_STATUS    = 4'h9;

    // control register bits
    localparam int CTRL_CYCLE_EN  = 0;
    localparam int CTRL_CARR_EN   = 1;
    localparam int CTRL_TOUT_EN   = 2;
    localparam int CTRL_MODE_LSB  = 4;
    localparam int CTRL_MODE_MSB  = 5;

    // carrier output control bits
    localparam int OUTC_GATE      = 0;
    localparam int OUTC_BUFFER    = 1;
    localparam int OUTC_REMOTE    = 2;

    // port register bits
    localparam int PORT_LATCH     = 0;
    localparam int PORT_DIR       = 1;

    // prescaler
    localparam int PRESCALE_W     = 8;
    localparam logic [2:0] CLKSEL_RST = 3'h0;

    localparam logic [7:0] BYTE_ZERO  = 8'h00;
    localparam logic [7:0] COUNT_ONE  = 8'h01;

    typedef enum logic [1:0] {
        MODE_INTERVAL = 2'b00,
        MODE_CARRIER  = 2'b01,
        MODE_PWM      = 2'b10
    } timer_mode_t;

endpackage : carrier_pwm_pkg

// [core/count_tick.sv]
`timescale 1ns/1ps
module count_tick
    import carrier_pwm_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       run,
    input  wire logic [2:0] clk_sel,
    output logic            tick
);

    typedef struct packed {
        logic [PRESCALE_W-1:0] div;
        logic                  level_q;
        logic                  tick;
    } tick_state_t;

    tick_state_t state;
    tick_state_t next_state;
    logic        level;

    // selected divider bit acts as the count clock
    always_comb begin
        level = (clk_sel == CLKSEL_RST) ? 1'b1 : state.div[clk_sel - 3'd1];
    end

    always_comb begin
        next_state = state;
        next_state.div = state.div + {{(PRESCALE_W-1){1'b0}}, 1'b1};
        next_state.level_q = level;
        // a start while the clock is high counts as a rising edge
        next_state.tick = run && (clk_sel == CLKSEL_RST || (level && !state.level_q)); // RL17
        if (!run) begin
            next_state.level_q = 1'b0;
            next_state.tick = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign tick = state.tick;

endmodule : count_tick

// [core/carrier_pwm_timer.sv]
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// RL1 - software stops both counters and disables output before carrier setup
// RL2 - software loads compares, mode, clocks, carrier output, buffer and gate bits
// RL3 - software sets pin output latch 0, enables output, then both counters
// RL4 - carrier counter makes carrier, cycle counter gates it periodically
// RL5 - low compare match raises irq, toggles carrier, selects high compare
// RL6 - high compare match raises irq, toggles carrier, selects low compare
// RL7 - cycle match raises irq; its rising edge copies buffer bit to gate
// RL8 - gate 1 passes carrier to pin, gate 0 holds pin low
// RL9 - software writes next gate value into buffer after each reload
// RL10 - output control register written whole byte while output disabled
// RL11 - buffer bit lost on carrier stop; software rewrites before restart
// RL12 - software PWM setup order: stop, disable, load, mode, pin, enable, start
// RL13 - PWM low compare sets low width, high compare sets high width
// RL14 - PWM low match raises irq, toggles, selects high, clears counter
// RL15 - PWM high match raises irq, toggles, selects low, clears counter
// RL16 - timer output starts low when output enable is set
// RL17 - first match after start may come up to 1.5 clocks early
// RL18 - compare value 00H matches after a single count pulse
// RL19 - clearing carrier enable forces timer output low
// RL20 - carrier mode counters restart from 00H after their match
// RL21 - shared pin carries timer output only while output enabled
module carrier_pwm_timer
    import carrier_pwm_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    output logic            shared_port_pin,
    output logic            port_direction_bit,
    output logic            carrier_match_irq,
    output logic            cycle_match_irq
);

    typedef struct packed {
        logic        cycle_count_enable;
        logic        carrier_count_enable;
        logic        timer_output_enable;
        timer_mode_t mode;
        logic [2:0]  cycle_clk_sel;
        logic [2:0]  carrier_clk_sel;
        logic [7:0]  cycle_compare;
        logic [7:0]  low_compare;
        logic [7:0]  high_compare;
        logic        remote_output_select;
        logic        level_buffer_bit;
        logic        level_gate_bit;
        logic        port_latch;
        logic        port_dir;
        logic [7:0]  cycle_counter;
        logic [7:0]  carrier_counter;
        logic        use_high;
        logic        carrier_level;
        logic        cycle_irq_q;
        logic        carrier_irq;
        logic        cycle_irq;
        logic        pin;
        logic [7:0]  rdata;
        logic        carrier_seen;
        logic        cycle_seen;
    } timer_state_t;

    timer_state_t state;
    timer_state_t next_state;

    logic       cycle_tick;
    logic       carrier_tick;
    logic       carrier_match;
    logic       cycle_match;
    logic [7:0] active_compare;
    logic       timer_out;
    logic       wr_ctrl;

    count_tick cycle_ticker (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .run      (state.cycle_count_enable),
        .clk_sel  (state.cycle_clk_sel),
        .tick     (cycle_tick)
    );

    count_tick carrier_ticker (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .run      (state.carrier_count_enable),
        .clk_sel  (state.carrier_clk_sel),
        .tick     (carrier_tick)
    );

    always_comb begin
        active_compare = state.use_high ? state.high_compare : state.low_compare; // RL13
        // counter value plus the pending pulse reaching the compare
        carrier_match = carrier_tick && (state.carrier_counter == active_compare); // RL18
        cycle_match = cycle_tick && (state.cycle_counter == state.cycle_compare); // RL18
        wr_ctrl = reg_write && (reg_addr == ADDR_CTRL);
    end

    // output level seen at the pin for the current mode
    always_comb begin
        if (state.mode == MODE_CARRIER) begin
            if (state.remote_output_select) begin
                timer_out = state.level_gate_bit;
            end else begin
                timer_out = state.level_gate_bit && state.carrier_level; // RL8
            end
        end else begin
            timer_out = state.carrier_level;
        end
    end

    always_comb begin
        next_state = state;
        next_state.carrier_irq = 1'b0;
        next_state.cycle_irq = 1'b0;

        // carrier counter: match toggles, swaps compare outside interval mode, clears
        if (state.carrier_count_enable && carrier_tick) begin
            if (carrier_match && state.mode != MODE_INTERVAL) begin
                next_state.carrier_irq = 1'b1; // RL5 RL6 RL14 RL15
                next_state.carrier_level = !state.carrier_level; // RL5 RL6 RL14 RL15
                next_state.use_high = !state.use_high; // RL5 RL6 RL14 RL15
                next_state.carrier_counter = BYTE_ZERO; // RL14 RL15 RL20
            end else if (carrier_match) begin
                next_state.carrier_irq = 1'b1;
                next_state.carrier_level = !state.carrier_level;
                next_state.carrier_counter = BYTE_ZERO;
            end else begin
                next_state.carrier_counter = state.carrier_counter + COUNT_ONE; // RL4
            end
        end

        // cycle counter drives the gate reload
        if (state.cycle_count_enable && cycle_tick) begin
            if (cycle_match) begin
                next_state.cycle_irq = 1'b1; // RL7
                next_state.cycle_counter = BYTE_ZERO; // RL20
            end else begin
                next_state.cycle_counter = state.cycle_counter + COUNT_ONE; // RL4
            end
        end
        next_state.cycle_irq_q = state.cycle_irq;

        // reload on the rising edge of the cycle match pulse
        if (state.cycle_irq && !state.cycle_irq_q && state.mode == MODE_CARRIER) begin
            next_state.level_gate_bit = state.level_buffer_bit; // RL7
        end

        if (state.carrier_irq) begin
            next_state.carrier_seen = 1'b1;
        end
        if (state.cycle_irq) begin
            next_state.cycle_seen = 1'b1;
        end

        // software writes
        if (reg_write) begin
            case (reg_addr)
                ADDR_CTRL: begin
                    next_state.cycle_count_enable = reg_wdata[CTRL_CYCLE_EN];
                    next_state.carrier_count_enable = reg_wdata[CTRL_CARR_EN];
                    next_state.timer_output_enable = reg_wdata[CTRL_TOUT_EN];
                    next_state.mode = timer_mode_t'(reg_wdata[CTRL_MODE_MSB:CTRL_MODE_LSB]);
                end
                ADDR_CLKSEL: begin
                    next_state.carrier_clk_sel = reg_wdata[2:0];
                    next_state.cycle_clk_sel = reg_wdata[6:4];
                end
                ADDR_CYCLE_CMP: begin
                    next_state.cycle_compare = reg_wdata;
                end
                ADDR_LOW_CMP: begin
                    next_state.low_compare = reg_wdata;
                end
                ADDR_HIGH_CMP: begin
                    next_state.high_compare = reg_wdata;
                end
                ADDR_OUT_CTRL: begin
                    next_state.remote_output_select = reg_wdata[OUTC_REMOTE];
                    next_state.level_buffer_bit = reg_wdata[OUTC_BUFFER];
                    next_state.level_gate_bit = reg_wdata[OUTC_GATE];
                end
                ADDR_PORT: begin
                    next_state.port_latch = reg_wdata[PORT_LATCH];
                    next_state.port_dir = reg_wdata[PORT_DIR];
                end
                ADDR_STATUS: begin
                    // write one to clear; a new event wins
                    if (reg_wdata[0] && !state.carrier_irq) begin
                        next_state.carrier_seen = 1'b0;
                    end
                    if (reg_wdata[1] && !state.cycle_irq) begin
                        next_state.cycle_seen = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // stopping a counter clears it; stopping the carrier counter also clears its level and compare select
        if (wr_ctrl && !reg_wdata[CTRL_CARR_EN]) begin
            next_state.carrier_counter = BYTE_ZERO;
            next_state.carrier_level = 1'b0; // RL19
            next_state.use_high = 1'b0;
        end
        if (wr_ctrl && !reg_wdata[CTRL_CYCLE_EN]) begin
            next_state.cycle_counter = BYTE_ZERO;
        end
        if (wr_ctrl && state.carrier_count_enable && !reg_wdata[CTRL_CARR_EN]
                && state.mode == MODE_CARRIER) begin
            next_state.level_buffer_bit = 1'b0; // RL11
        end
        if (wr_ctrl && reg_wdata[CTRL_TOUT_EN] && !state.timer_output_enable) begin
            next_state.carrier_level = 1'b0; // RL16
        end

        // pin: timer output only when enabled, else port latch
        if (state.timer_output_enable) begin
            next_state.pin = timer_out && state.carrier_count_enable; // RL21 RL19
        end else begin
            next_state.pin = state.port_latch; // RL21
        end

        // read data, one cycle after the strobe
        next_state.rdata = BYTE_ZERO;
        if (reg_read) begin
            case (reg_addr)
                ADDR_CTRL: begin
                    next_state.rdata[CTRL_CYCLE_EN] = state.cycle_count_enable;
                    next_state.rdata[CTRL_CARR_EN] = state.carrier_count_enable;
                    next_state.rdata[CTRL_TOUT_EN] = state.timer_output_enable;
                    next_state.rdata[CTRL_MODE_MSB:CTRL_MODE_LSB] = state.mode;
                end
                ADDR_CLKSEL: begin
                    next_state.rdata = {1'b0, state.cycle_clk_sel, 1'b0, state.carrier_clk_sel};
                end
                ADDR_CYCLE_CMP: begin
                    next_state.rdata = state.cycle_compare;
                end
                ADDR_LOW_CMP: begin
                    next_state.rdata = state.low_compare;
                end
                ADDR_HIGH_CMP: begin
                    next_state.rdata = state.high_compare;
                end
                ADDR_OUT_CTRL: begin
                    next_state.rdata[OUTC_REMOTE] = state.remote_output_select;
                    next_state.rdata[OUTC_BUFFER] = state.level_buffer_bit;
                    next_state.rdata[OUTC_GATE] = state.level_gate_bit;
                end
                ADDR_PORT: begin
                    next_state.rdata[PORT_LATCH] = state.port_latch;
                    next_state.rdata[PORT_DIR] = state.port_dir;
                end
                ADDR_CYCLE_CNT: begin
                    next_state.rdata = state.cycle_counter;
                end
                ADDR_CARR_CNT: begin
                    next_state.rdata = state.carrier_counter;
                end
                ADDR_STATUS: begin
                    next_state.rdata = {4'h0, state.pin, state.use_high,
                                        state.cycle_seen, state.carrier_seen};
                end
                default: begin
                    next_state.rdata = BYTE_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= '0;
            state.port_dir <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign reg_rdata          = state.rdata;
    assign shared_port_pin    = state.pin;
    assign port_direction_bit = state.port_dir;
    assign carrier_match_irq  = state.carrier_irq;
    assign cycle_match_irq    = state.cycle_irq;

endmodule : carrier_pwm_timer

// [tb/carrier_pwm_checker_assertions.sv]
`timescale 1ns/1ps
module carrier_pwm_checker
    import carrier_pwm_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic       shared_port_pin,
    input wire logic       port_direction_bit,
    input wire logic       carrier_match_irq,
    input wire logic       cycle_match_irq
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    logic       ten;
    logic       cen;
    logic       cyc;
    logic       lat;
    logic       rem;
    logic       seen;
    logic [1:0] quiet;
    logic [2:0] cs;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [8:0] gap;
    logic       wctl;
    logic       wprt;

    assign wctl = reg_write && reg_addr == ADDR_CTRL;
    assign wprt = reg_write && reg_addr == ADDR_PORT;

    // shadow of the settings software has written
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            {ten, cen, cyc, lat, rem, seen} <= 6'h00;
            quiet <= 2'h0;
            cs    <= CLKSEL_RST;
            lo    <= BYTE_ZERO;
            hi    <= BYTE_ZERO;
            gap   <= 9'h000;
        end else begin
            if (wctl) begin
                ten <= reg_wdata[CTRL_TOUT_EN];
                cen <= reg_wdata[CTRL_CARR_EN];
                cyc <= reg_wdata[CTRL_CYCLE_EN];
            end
            if (wprt) begin
                lat <= reg_wdata[PORT_LATCH];
            end
            if (reg_write && reg_addr == ADDR_OUT_CTRL) begin
                rem <= reg_wdata[OUTC_REMOTE];
            end
            if (reg_write && reg_addr == ADDR_CLKSEL) begin
                cs <= reg_wdata[2:0];
            end
            if (reg_write && reg_addr == ADDR_LOW_CMP) begin
                lo <= reg_wdata;
            end
            if (reg_write && reg_addr == ADDR_HIGH_CMP) begin
                hi <= reg_wdata;
            end
            quiet <= (wctl || wprt) ? 2'h0 : ((quiet == 2'h3) ? quiet : quiet + 2'h1);
            seen  <= cen && (seen || carrier_match_irq);
            gap   <= carrier_match_irq ? 9'h001 : gap + 9'h001;
        end
    end

    a_reset_out: assert property (disable iff (1'b0) sys_rst |=> port_direction_bit &&
        !shared_port_pin && !carrier_match_irq && !cycle_match_irq) else $error("reset state");
    a_dir_write: assert property (wprt |=> port_direction_bit == $past(reg_wdata[PORT_DIR]))
        else $error("direction bit not written");
    a_port_read: assert property (reg_read && reg_addr == ADDR_PORT
        |=> reg_rdata[1:0] == {port_direction_bit, lat}) else $error("port read");
    a_pin_latch: assert property (quiet == 2'h3 && !ten |-> shared_port_pin == lat)
        else $error("pin not on latch");
    a_start_low: assert property ($rose(ten) |=> !shared_port_pin)
        else $error("output not low at enable");
    a_stop_low: assert property (ten && !rem && $fell(cen) |=> !shared_port_pin)
        else $error("output not low after stop");
    a_irq_enabled: assert property (carrier_match_irq |-> $past(cen, 2) || $past(cen, 3))
        else $error("carrier irq while stopped");
    a_cycle_enabled: assert property (cycle_match_irq |-> $past(cyc, 2) || $past(cyc, 3))
        else $error("cycle irq while stopped");
    a_carr_period: assert property (seen && cs == 3'h0 && carrier_match_irq
        |-> gap == {1'b0, lo} + 9'h001 || gap == {1'b0, hi} + 9'h001) else $error("match spacing");

    c_period: cover property (seen && carrier_match_irq);
    c_cycle: cover property (cycle_match_irq);
    c_stop: cover property (ten && $fell(cen));
endmodule : carrier_pwm_checker

bind carrier_pwm_timer carrier_pwm_checker carrier_pwm_checker_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .shared_port_pin(shared_port_pin), .port_direction_bit(port_direction_bit),
    .carrier_match_irq(carrier_match_irq), .cycle_match_irq(cycle_match_irq));

// [tb/pin_load.sv]
`timescale 1ns/1ps
module pin_load (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        shared_port_pin,
    output logic      [15:0] rises
);
    logic prev;

    // counts rising edges seen by the load
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prev  <= 1'b0;
            rises <= 16'h0000;
        end else begin
            prev <= shared_port_pin;
            if (shared_port_pin && !prev) begin
                rises <= rises + 16'h0001;
            end
        end
    end
endmodule : pin_load

// [tb/tb.sv]
`timescale 1ns/1ps
module tb import carrier_pwm_pkg::*;;
    logic        core_clk  = 1'b0;
    logic        sys_rst   = 1'b1;
    logic [3:0]  reg_addr  = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_write = 1'b0;
    logic        reg_read  = 1'b0;
    logic [7:0]  reg_rdata;
    logic        shared_port_pin;
    logic        port_direction_bit;
    logic        carrier_match_irq;
    logic        cycle_match_irq;
    logic [15:0] rises;
    logic [15:0] r0;
    int          errors    = 0;
    int          compares  = 0;
    int          n;

    always #20 core_clk = ~core_clk;

    carrier_pwm_timer carrier_pwm_timer_i (
        .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .shared_port_pin(shared_port_pin), .port_direction_bit(port_direction_bit),
        .carrier_match_irq(carrier_match_irq), .cycle_match_irq(cycle_match_irq));
    pin_load pin_load_i (.core_clk(core_clk), .sys_rst(sys_rst),
        .shared_port_pin(shared_port_pin), .rises(rises));

    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask : wr

    task rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1;
        chk({8'h00, reg_rdata & m}, {8'h00, e});
    endtask : rd

    // cycles left in the run of level v in progress, else length of the next one
    task run_len(input logic v, output int k);
        k = 0;
        while (shared_port_pin !== v && k < 300) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        k = 0;
        while (shared_port_pin === v && k < 300) begin
            @(posedge core_clk);
            #1;
            k++;
        end
    endtask : run_len

    task wait_irq(input bit c, output int k);
        k = 0;
        do begin
            @(posedge core_clk);
            #1;
            k++;
        end while ((c ? cycle_match_irq : carrier_match_irq) !== 1'b1 && k < 2000);
        if (k >= 2000) begin
            errors++;
            $display("BAD %0t no interrupt", $time);
        end
    endtask : wait_irq

    task close_out;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    initial begin
        #200000;
        errors++;
        close_out;
    end

    initial begin
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        #1;
        chk(port_direction_bit, 16'h0001);
        rd(ADDR_CTRL, 8'hFF, 8'h00);
        rd(4'hF, 8'hFF, 8'h00);
        wr(ADDR_PORT, 8'h01);
        rd(ADDR_PORT, 8'h03, 8'h01);
        repeat (2) @(posedge core_clk);
        #1;
        chk(shared_port_pin, 16'h0001);
        wr(ADDR_PORT, 8'h00);
        $display("port test done");
        wr(ADDR_LOW_CMP, 8'h02);
        wr(ADDR_HIGH_CMP, 8'h04);
        wr(ADDR_CLKSEL, 8'h00);
        wr(ADDR_CTRL, 8'h20);
        wr(ADDR_CTRL, 8'h24);
        wr(ADDR_CTRL, 8'h26);
        run_len(1'b0, n);
        run_len(1'b1, n);
        chk(16'(n), 16'h0005);
        run_len(1'b0, n);
        chk(16'(n), 16'h0003);
        run_len(1'b0, n);
        wr(ADDR_CTRL, 8'h24);
        repeat (2) @(posedge core_clk);
        #1;
        chk(shared_port_pin, 16'h0000);
        wr(ADDR_CTRL, 8'h00);
        $display("pwm test done");
        wr(ADDR_CYCLE_CMP, 8'h1F);
        wr(ADDR_LOW_CMP, 8'h00);
        wr(ADDR_HIGH_CMP, 8'h00);
        wr(ADDR_CTRL, 8'h10);
        wr(ADDR_OUT_CTRL, 8'h02);
        wr(ADDR_CTRL, 8'h14);
        wr(ADDR_CTRL, 8'h17);
        r0 = rises;
        repeat (6) @(posedge core_clk);
        #1;
        chk(rises, r0);
        wait_irq(1'b1, n);
        rd(ADDR_OUT_CTRL, 8'h03, 8'h03);
        wr(ADDR_OUT_CTRL, 8'h01);
        run_len(1'b0, n);
        run_len(1'b1, n);
        chk(16'(n), 16'h0001);
        run_len(1'b0, n);
        chk(16'(n), 16'h0001);
        wait_irq(1'b1, n);
        wait_irq(1'b1, n);
        chk(16'(n), 16'h0020);
        r0 = rises;
        repeat (8) @(posedge core_clk);
        #1;
        chk(rises, r0);
        wr(ADDR_OUT_CTRL, 8'h02);
        wr(ADDR_CTRL, 8'h10);
        rd(ADDR_OUT_CTRL, 8'h02, 8'h00);
        wr(ADDR_CTRL, 8'h00);
        rd(ADDR_STATUS, 8'h0F, 8'h03);
        wr(ADDR_STATUS, 8'h03);
        rd(ADDR_STATUS, 8'h03, 8'h00);
        $display("carrier test done");
        close_out;
    end
endmodule : tb
